// File: rtdc_params.svh
// Constants of the temperature alarm combiner: sizes, register map, bit positions, timing.
// Assumes inclusion by bare name from every design file.
`ifndef RTDC_PARAMS_SVH
`define RTDC_PARAMS_SVH
`define RTDC_NUM_SENSORS   12
`define RTDC_NUM_GROUPS    4
`define RTDC_TEMP_W        16
`define RTDC_DELAY_W       16
`define RTDC_CNT_W         4
`define RTDC_DROP_NUM      99
`define RTDC_DROP_DEN      100
`define RTDC_WD_BASE       0
`define RTDC_WD_SIZE       6
`define RTDC_MB_BASE       6
`define RTDC_MB_SIZE       2
`define RTDC_LB_BASE       8
`define RTDC_LB_SIZE       2
`define RTDC_AUX_BASE      10
`define RTDC_AUX_SIZE      2
`define RTDC_CLK_PERIOD_NS 10
`define RTDC_TICK_NS       1000000
`define RTDC_TICK_CYCLES   ((`RTDC_TICK_NS + `RTDC_CLK_PERIOD_NS - 1) / `RTDC_CLK_PERIOD_NS)
`define RTDC_ADDR_W        8
`define RTDC_OFS_CTRL      8'h00
`define RTDC_OFS_CHAN      8'h04
`define RTDC_OFS_VSEL1     8'h08
`define RTDC_OFS_VSEL2     8'h0C
`define RTDC_OFS_VCNT      8'h10
`define RTDC_OFS_DELAY     8'h14
`define RTDC_OFS_THR0      8'h20
`define RTDC_OFS_STATUS    8'h30
`define RTDC_OFS_MASK      8'h34
`define RTDC_OFS_FLAGS     8'h38
`define RTDC_CTRL_ACTIVE   0
`define RTDC_CTRL_VOTESRC  1
`define RTDC_VCNT_REQ2_LSB 4
`define RTDC_VCNT_EN1      8
`define RTDC_VCNT_EN2      9
`define RTDC_THR_TRIP_LSB  16
`define RTDC_EV_W          6
`define RTDC_EV_ALARM      0
`define RTDC_EV_TIMEOUT    1
`define RTDC_EV_TRIP       2
`define RTDC_EV_VOTE1      3
`define RTDC_EV_VOTE2      4
`define RTDC_EV_TRIPCMD    5
`define RTDC_RST_WORD      32'h0000_0000
`define RTDC_RST_THR       16'hFFFF
`define RTDC_RST_DELAY     16'h0000
`endif

// File: rtdc_pkg.sv
// Types shared by the temperature alarm combiner.
// Assumes rtdc_params.svh is on the include path.
`include "rtdc_params.svh"
package rtdc_pkg;
  typedef logic [`RTDC_TEMP_W-1:0] rtdc_temp_t;
  typedef logic [`RTDC_EV_W-1:0] rtdc_event_t;
  typedef enum logic [1:0] {
    GRP_WINDING       = 2'h0,
    GRP_MOTOR_BEARING = 2'h1,
    GRP_LOAD_BEARING  = 2'h2,
    GRP_AUXILIARY     = 2'h3
  } rtdc_group_e;
endpackage

// File: rtdc_group_stage.sv
// One sensor group: hottest member against group alarm and trip levels.
// Assumes same-clock registered inputs and a one-cycle tick for the alarm delay.
`timescale 1ns/1ns
`include "rtdc_params.svh"
module rtdc_group_stage #(
  parameter int N  = `RTDC_WD_SIZE,
  parameter int W  = `RTDC_TEMP_W,
  parameter int DW = `RTDC_DELAY_W
) (
  input  wire logic           mclk,
  input  wire logic           rst_b,
  input  wire logic           tick,
  input  wire logic [N*W-1:0] temps,
  input  wire logic [N-1:0]   active,
  input  wire logic [W-1:0]   alarmThr,
  input  wire logic [W-1:0]   tripThr,
  input  wire logic [DW-1:0]  alarmDelay,
  output logic                alarm,
  output logic                trip
);
  localparam int PW = W + 7;

  logic [W-1:0]  maxT;
  logic          overQ;
  logic          overD;
  logic          tripQ;
  logic          tripD;
  logic          alarmQ;
  logic          alarmD;
  logic [DW-1:0] cntQ;
  logic [DW-1:0] cntD;

  function automatic logic [W-1:0] dropLevel(input logic [W-1:0] thr);
    logic [PW-1:0] prod;
    prod = PW'(thr) * PW'(`RTDC_DROP_NUM);
    return W'(prod / PW'(`RTDC_DROP_DEN));
  endfunction

  function automatic logic [W-1:0] hottest(input logic [N*W-1:0] t, input logic [N-1:0] act);
    logic [W-1:0] m;
    m = '0;
    for (int i = 0; i < N; i++) begin
      if (act[i] && t[i*W +: W] > m) begin
        m = t[i*W +: W];
      end
    end
    return m;
  endfunction

  always_comb begin
    maxT = hottest(temps, active);
    overD = overQ;
    tripD = tripQ;
    if (!(|active)) begin
      overD = 1'b0;
      tripD = 1'b0;
    end else begin
      if (maxT >= alarmThr) begin
        overD = 1'b1;
      end else if (maxT < dropLevel(alarmThr)) begin
        overD = 1'b0;
      end
      if (maxT >= tripThr) begin
        tripD = 1'b1;
      end else if (maxT < dropLevel(tripThr)) begin
        tripD = 1'b0;
      end
    end
    cntD = cntQ;
    if (!overD) begin
      cntD = '0;
    end else if (tick && cntQ < alarmDelay) begin
      cntD = cntQ + DW'(1);
    end
    alarmD = overD && (cntQ >= alarmDelay);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      overQ  <= 1'b0;
      tripQ  <= 1'b0;
      alarmQ <= 1'b0;
      cntQ   <= '0;
    end else begin
      overQ  <= overD;
      tripQ  <= tripD;
      alarmQ <= alarmD;
      cntQ   <= cntD;
    end
  end

  assign alarm = alarmQ;
  assign trip  = tripQ;

  property p_tripUndelayed;
    @(posedge mclk) disable iff (!rst_b) ((|active) && maxT >= tripThr) |=> trip;
  endproperty
  a_tripUndelayed: assert property (p_tripUndelayed) else $error("Group trip not raised at once");

  property p_hold;
    @(posedge mclk) disable iff (!rst_b) (trip && (|active) && maxT >= dropLevel(tripThr)) |=> trip;
  endproperty
  a_hold: assert property (p_hold) else $error("Group trip dropped above dropout level");

  property p_alarmAfterDelay;
    @(posedge mclk) disable iff (!rst_b) $rose(alarm) |-> $past(overD) && $past(cntQ) >= $past(alarmDelay);
  endproperty
  a_alarmAfterDelay: assert property (p_alarmAfterDelay) else $error("Group alarm before delay ran out");

  property p_hottest;
    @(posedge mclk) disable iff (!rst_b) (!overQ && maxT < alarmThr) |=> !overQ;
  endproperty
  a_hottest: assert property (p_hottest) else $error("Group over-alarm set below level");
endmodule

// File: rtdc_vote.sv
// One voting group: counts tripped selected sensors against a required count.
// Assumes same-clock registered sensor trips and configuration.
`timescale 1ns/1ns
`include "rtdc_params.svh"
module rtdc_vote #(
  parameter int N  = `RTDC_NUM_SENSORS,
  parameter int CW = `RTDC_CNT_W
) (
  input  wire logic          mclk,
  input  wire logic          rst_b,
  input  wire logic [N-1:0]  trips,
  input  wire logic [N-1:0]  select,
  input  wire logic [N-1:0]  active,
  input  wire logic [CW-1:0] required,
  input  wire logic          enable,
  output logic               voteTrip
);
  logic [CW-1:0] votes;
  logic          voteQ;
  logic          voteD;

  function automatic logic [CW-1:0] popCount(input logic [N-1:0] v);
    logic [CW-1:0] c;
    c = '0;
    for (int i = 0; i < N; i++) begin
      c = c + CW'(v[i]);
    end
    return c;
  endfunction

  always_comb begin
    votes = popCount(trips & select & active);
    voteD = enable && (required != '0) && (votes >= required);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      voteQ <= 1'b0;
    end else begin
      voteQ <= voteD;
    end
  end

  assign voteTrip = voteQ;

  property p_voteReach;
    @(posedge mclk) disable iff (!rst_b) (enable && required != '0 && votes >= required) |=> voteTrip;
  endproperty
  a_voteReach: assert property (p_voteReach) else $error("Vote trip missing at required count");

  property p_voteInactive;
    @(posedge mclk) disable iff (!rst_b) voteTrip |-> $past(popCount(trips & select & active)) >= $past(required);
  endproperty
  a_voteInactive: assert property (p_voteInactive) else $error("Vote trip without enough active votes");
endmodule

// File: rtdc_combiner.sv
// Top of the temperature alarm combiner: sensor flag capture, groups, voting, registers, interrupt.
// Assumes per-sensor threshold stages on mclk and an Avalon-MM master with waitrequest.
`timescale 1ns/1ns
`include "rtdc_params.svh"
// Overview of operation
// - Combined alarm high when any of the four group alarms is high.
// - Combined timeout alarm high when any group timeout alarm is high.
// - Combined trip high when any sensor of any group trips.
// - Each group compares only its hottest member against its thresholds.
// - Group timeout alarm looks at every member sensor of that group.
// - Group threshold alarms wait for the configured delay, sensor alarm flags pass at once; trips have no intended delay.
// - Six winding, two motor bearing, two load bearing, two auxiliary sensors.
// - Voting trip once tripped members reach the required count.
// - Any of twelve sensor trips selectable in either vote group.
// - Collective timeout when any sensor or group timeout alarm is high.
// - Alarm and trip drop out only below 0.99 of threshold.
// - Voting member must be selected, channel active, module active.
// - Trip command follows votes when source is voting, else sensor trips.
module rtdc_combiner #(
  parameter int N           = `RTDC_NUM_SENSORS,
  parameter int W           = `RTDC_TEMP_W,
  parameter int DW          = `RTDC_DELAY_W,
  parameter int CW          = `RTDC_CNT_W,
  parameter int TICK_CYCLES = `RTDC_TICK_CYCLES
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  input  wire logic [N*W-1:0]          sensorTemp,
  input  wire logic [N-1:0]            sensorAlarm,
  input  wire logic [N-1:0]            sensorTimeout,
  input  wire logic [N-1:0]            sensorTrip,
  input  wire logic [`RTDC_ADDR_W-1:0] avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  output logic [`RTDC_NUM_GROUPS-1:0]  groupAlarm,
  output logic [`RTDC_NUM_GROUPS-1:0]  groupTimeout,
  output logic [`RTDC_NUM_GROUPS-1:0]  groupTrip,
  output logic                         combinedAlarm,
  output logic                         combinedTimeoutAlarm,
  output logic                         combinedTrip,
  output logic                         collectiveTimeout,
  output logic                         voteTrip1,
  output logic                         voteTrip2,
  output logic                         tripCmd,
  output logic                         irq
);
  localparam int NG  = `RTDC_NUM_GROUPS;
  localparam int TCW = $clog2(TICK_CYCLES + 1);

  function automatic int grpBase(input int g);
    case (rtdc_pkg::rtdc_group_e'(g))
      rtdc_pkg::GRP_WINDING:       return `RTDC_WD_BASE;
      rtdc_pkg::GRP_MOTOR_BEARING: return `RTDC_MB_BASE;
      rtdc_pkg::GRP_LOAD_BEARING:  return `RTDC_LB_BASE;
      default:                     return `RTDC_AUX_BASE;
    endcase
  endfunction

  function automatic int grpSize(input int g);
    case (rtdc_pkg::rtdc_group_e'(g))
      rtdc_pkg::GRP_WINDING:       return `RTDC_WD_SIZE;
      rtdc_pkg::GRP_MOTOR_BEARING: return `RTDC_MB_SIZE;
      rtdc_pkg::GRP_LOAD_BEARING:  return `RTDC_LB_SIZE;
      default:                     return `RTDC_AUX_SIZE;
    endcase
  endfunction

  function automatic logic [`RTDC_ADDR_W-1:0] thrOfs(input int g);
    return `RTDC_OFS_THR0 + `RTDC_ADDR_W'(4 * g);
  endfunction

  function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Register file state
  logic [31:0]             ctrlQ, ctrlD;
  logic [N-1:0]            chanQ, chanD;
  logic [N-1:0]            vsel1Q, vsel1D;
  logic [N-1:0]            vsel2Q, vsel2D;
  logic [31:0]             vcntQ, vcntD;
  logic [DW-1:0]           delayQ, delayD;
  logic [31:0]             thrQ [NG];
  logic [31:0]             thrD [NG];
  rtdc_pkg::rtdc_event_t   statusQ, statusD;
  rtdc_pkg::rtdc_event_t   maskQ, maskD;
  logic [31:0]             rdQ, rdD;
  logic                    ackQ, ackD;
  logic                    reqStart;
  logic                    wrAck;
  logic                    rdAck;
  logic [31:0]             flagsWord;

  // Datapath state
  logic [N*W-1:0]          tempQ;
  logic [N-1:0]            alarmInQ, timeoutInQ, tripInQ;
  logic [TCW-1:0]          tickCntQ, tickCntD;
  logic                    tick;
  logic                    moduleActive;
  logic [N-1:0]            activeVec;
  logic [N-1:0]            alarmGated, timeoutGated, tripGated;
  logic [NG-1:0]           stageAlarm, stageTrip;
  logic [NG-1:0]           memberAlarm, memberTimeout, memberTrip;
  logic                    vote1, vote2;
  rtdc_pkg::rtdc_event_t   evNow, evPrevQ, evRise;
  logic [NG-1:0]           gAlarmQ, gAlarmD, gTimeoutQ, gTimeoutD, gTripQ, gTripD;
  logic                    anyAlarmQ, anyAlarmD, anyTimeoutQ, anyTimeoutD, anyTripQ, anyTripD;
  logic                    collQ, collD, v1Q, v2Q, cmdQ, cmdD;

  // Bus slave: one wait state, read data registered at the first edge
  assign reqStart        = (avs_read || avs_write) && !ackQ;
  assign avs_waitrequest = (avs_read || avs_write) && !ackQ;
  assign wrAck           = avs_write && ackQ;
  assign rdAck           = avs_read && ackQ;
  assign flagsWord       = 32'(evNow);

  always_comb begin
    ackD    = reqStart;
    rdD     = rdQ;
    ctrlD   = ctrlQ;
    chanD   = chanQ;
    vsel1D  = vsel1Q;
    vsel2D  = vsel2Q;
    vcntD   = vcntQ;
    delayD  = delayQ;
    maskD   = maskQ;
    thrD    = thrQ;
    if (reqStart && avs_read) begin
      rdD = `RTDC_RST_WORD;
      unique case (avs_address)
        `RTDC_OFS_CTRL:   rdD = ctrlQ;
        `RTDC_OFS_CHAN:   rdD = 32'(chanQ);
        `RTDC_OFS_VSEL1:  rdD = 32'(vsel1Q);
        `RTDC_OFS_VSEL2:  rdD = 32'(vsel2Q);
        `RTDC_OFS_VCNT:   rdD = vcntQ;
        `RTDC_OFS_DELAY:  rdD = 32'(delayQ);
        `RTDC_OFS_STATUS: rdD = 32'(statusQ);
        `RTDC_OFS_MASK:   rdD = 32'(maskQ);
        `RTDC_OFS_FLAGS:  rdD = flagsWord;
        default: begin
          for (int g = 0; g < NG; g++) begin
            if (avs_address == thrOfs(g)) begin
              rdD = thrQ[g];
            end
          end
        end
      endcase
    end
    if (wrAck) begin
      unique case (avs_address)
        `RTDC_OFS_CTRL:  ctrlD = byteMerge(ctrlQ, avs_writedata, avs_byteenable) & 32'h0000_0003;
        `RTDC_OFS_CHAN:  chanD = N'(byteMerge(32'(chanQ), avs_writedata, avs_byteenable));
        `RTDC_OFS_VSEL1: vsel1D = N'(byteMerge(32'(vsel1Q), avs_writedata, avs_byteenable));
        `RTDC_OFS_VSEL2: vsel2D = N'(byteMerge(32'(vsel2Q), avs_writedata, avs_byteenable));
        `RTDC_OFS_VCNT:  vcntD = byteMerge(vcntQ, avs_writedata, avs_byteenable) & 32'h0000_03FF;
        `RTDC_OFS_DELAY: delayD = DW'(byteMerge(32'(delayQ), avs_writedata, avs_byteenable));
        `RTDC_OFS_MASK:  maskD = `RTDC_EV_W'(byteMerge(32'(maskQ), avs_writedata, avs_byteenable));
        default: begin
          for (int g = 0; g < NG; g++) begin
            if (avs_address == thrOfs(g)) begin
              thrD[g] = byteMerge(thrQ[g], avs_writedata, avs_byteenable);
            end
          end
        end
      endcase
    end
    // Only bits actually returned are cleared, so an event during the wait state survives
    statusD = evRise | (statusQ & ~((rdAck && avs_address == `RTDC_OFS_STATUS) ? `RTDC_EV_W'(rdQ) : '0));
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ackQ    <= 1'b0;
      rdQ     <= `RTDC_RST_WORD;
      ctrlQ   <= `RTDC_RST_WORD;
      chanQ   <= '0;
      vsel1Q  <= '0;
      vsel2Q  <= '0;
      vcntQ   <= `RTDC_RST_WORD;
      delayQ  <= `RTDC_RST_DELAY;
      statusQ <= '0;
      maskQ   <= '0;
      for (int g = 0; g < NG; g++) begin
        thrQ[g] <= {`RTDC_RST_THR, `RTDC_RST_THR};
      end
    end else begin
      ackQ    <= ackD;
      rdQ     <= rdD;
      ctrlQ   <= ctrlD;
      chanQ   <= chanD;
      vsel1Q  <= vsel1D;
      vsel2Q  <= vsel2D;
      vcntQ   <= vcntD;
      delayQ  <= delayD;
      statusQ <= statusD;
      maskQ   <= maskD;
      thrQ    <= thrD;
    end
  end

  assign avs_readdata = rdQ;
  assign irq          = |(statusQ & maskQ);

  // Millisecond tick for alarm delays
  always_comb begin
    tick     = (tickCntQ == TCW'(TICK_CYCLES - 1));
    tickCntD = tick ? '0 : tickCntQ + TCW'(1);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tickCntQ <= '0;
    end else begin
      tickCntQ <= tickCntD;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tempQ      <= '0;
      alarmInQ   <= '0;
      timeoutInQ <= '0;
      tripInQ    <= '0;
    end else begin
      tempQ      <= sensorTemp;
      alarmInQ   <= sensorAlarm;
      timeoutInQ <= sensorTimeout;
      tripInQ    <= sensorTrip;
    end
  end

  assign moduleActive = ctrlQ[`RTDC_CTRL_ACTIVE];
  assign activeVec    = chanQ & {N{moduleActive}};
  assign alarmGated   = alarmInQ & activeVec;
  assign timeoutGated = timeoutInQ & activeVec;
  assign tripGated    = tripInQ & activeVec;

  for (genvar g = 0; g < NG; g++) begin : gGrp
    localparam int B = grpBase(g);
    localparam int S = grpSize(g);
    rtdc_group_stage #(
      .N  (S),
      .W  (W),
      .DW (DW)
    ) uStage (
      .mclk       (mclk),
      .rst_b      (rst_b),
      .tick       (tick),
      .temps      (tempQ[B*W +: S*W]),
      .active     (activeVec[B +: S]),
      .alarmThr   (thrQ[g][W-1:0]),
      .tripThr    (thrQ[g][`RTDC_THR_TRIP_LSB +: W]),
      .alarmDelay (delayQ),
      .alarm      (stageAlarm[g]),
      .trip       (stageTrip[g])
    );
    assign memberAlarm[g]   = |alarmGated[B +: S];
    assign memberTimeout[g] = |timeoutGated[B +: S];
    assign memberTrip[g]    = |tripGated[B +: S];
  end

  rtdc_vote #(
    .N  (N),
    .CW (CW)
  ) uVote1 (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .trips    (tripGated),
    .select   (vsel1Q),
    .active   (activeVec),
    .required (vcntQ[CW-1:0]),
    .enable   (vcntQ[`RTDC_VCNT_EN1]),
    .voteTrip (vote1)
  );

  rtdc_vote #(
    .N  (N),
    .CW (CW)
  ) uVote2 (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .trips    (tripGated),
    .select   (vsel2Q),
    .active   (activeVec),
    .required (vcntQ[`RTDC_VCNT_REQ2_LSB +: CW]),
    .enable   (vcntQ[`RTDC_VCNT_EN2]),
    .voteTrip (vote2)
  );

  always_comb begin
    gAlarmD     = stageAlarm | memberAlarm;
    gTimeoutD   = memberTimeout;
    gTripD      = stageTrip | memberTrip;
    anyAlarmD   = |gAlarmD;
    anyTimeoutD = |gTimeoutD;
    anyTripD    = |gTripD;
    collD       = (|timeoutGated) || anyTimeoutD;
    cmdD        = ctrlQ[`RTDC_CTRL_VOTESRC] ? (vote1 || vote2) : anyTripD;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gAlarmQ     <= '0;
      gTimeoutQ   <= '0;
      gTripQ      <= '0;
      anyAlarmQ   <= 1'b0;
      anyTimeoutQ <= 1'b0;
      anyTripQ    <= 1'b0;
      collQ       <= 1'b0;
      v1Q         <= 1'b0;
      v2Q         <= 1'b0;
      cmdQ        <= 1'b0;
      evPrevQ     <= '0;
    end else begin
      gAlarmQ     <= gAlarmD;
      gTimeoutQ   <= gTimeoutD;
      gTripQ      <= gTripD;
      anyAlarmQ   <= anyAlarmD;
      anyTimeoutQ <= anyTimeoutD;
      anyTripQ    <= anyTripD;
      collQ       <= collD;
      v1Q         <= vote1;
      v2Q         <= vote2;
      cmdQ        <= cmdD;
      evPrevQ     <= evNow;
    end
  end

  assign evNow  = {cmdQ, v2Q, v1Q, anyTripQ, anyTimeoutQ, anyAlarmQ};
  assign evRise = evNow & ~evPrevQ;

  assign groupAlarm           = gAlarmQ;
  assign groupTimeout         = gTimeoutQ;
  assign groupTrip            = gTripQ;
  assign combinedAlarm        = anyAlarmQ;
  assign combinedTimeoutAlarm = anyTimeoutQ;
  assign combinedTrip         = anyTripQ;
  assign collectiveTimeout    = collQ;
  assign voteTrip1            = v1Q;
  assign voteTrip2            = v2Q;
  assign tripCmd              = cmdQ;

  property p_anyAlarm;
    @(posedge mclk) disable iff (!rst_b) (|(stageAlarm | memberAlarm)) |=> combinedAlarm;
  endproperty
  a_anyAlarm: assert property (p_anyAlarm) else $error("Combined alarm missed a group alarm");

  property p_anyTimeout;
    @(posedge mclk) disable iff (!rst_b) combinedTimeoutAlarm == (|groupTimeout);
  endproperty
  a_anyTimeout: assert property (p_anyTimeout) else $error("Combined timeout disagrees with groups");

  property p_anyTrip;
    @(posedge mclk) disable iff (!rst_b) (|(sensorTrip & activeVec)) ##1 $stable(activeVec) |=> combinedTrip;
  endproperty
  a_anyTrip: assert property (p_anyTrip) else $error("Combined trip missed a sensor trip");

  property p_collective;
    @(posedge mclk) disable iff (!rst_b) (combinedTimeoutAlarm || $past(|timeoutGated)) |-> collectiveTimeout;
  endproperty
  a_collective: assert property (p_collective) else $error("Collective timeout missed a source");

  property p_cmdVote;
    @(posedge mclk) disable iff (!rst_b) (ctrlQ[`RTDC_CTRL_VOTESRC] && (vote1 || vote2)) |=> tripCmd;
  endproperty
  a_cmdVote: assert property (p_cmdVote) else $error("Voting trip did not reach trip command");

  property p_cmdDefault;
    @(posedge mclk) disable iff (!rst_b) (tripCmd && !$past(ctrlQ[`RTDC_CTRL_VOTESRC])) |-> $past(anyTripD);
  endproperty
  a_cmdDefault: assert property (p_cmdDefault) else $error("Trip command without sensor trip");

  property p_inactive;
    @(posedge mclk) disable iff (!rst_b) (!moduleActive)[*3] |-> !combinedTrip && !voteTrip1 && !voteTrip2;
  endproperty
  a_inactive: assert property (p_inactive) else $error("Trip while module inactive");

  property p_statusSetWins;
    @(posedge mclk) disable iff (!rst_b) evRise[`RTDC_EV_ALARM] |=> statusQ[`RTDC_EV_ALARM];
  endproperty
  a_statusSetWins: assert property (p_statusSetWins) else $error("Alarm event lost in status");
endmodule

// File: rtdc_stage_model.sv
// Model of the per-sensor threshold stages that feed the combiner.
// Assumes the bench sets the wanted flags; they reach the pins one edge later.
`timescale 1ns/1ns
module rtdc_stage_model (
  input  wire logic        mclk,
  input  wire logic [35:0] want,
  input  wire logic [15:0] hot,
  output logic      [191:0] temp,
  output logic      [11:0]  alm,
  output logic      [11:0]  tmo,
  output logic      [11:0]  trp
);
  // Sensor 0 runs hottest, the rest at half, so a group must pick its hottest member
  assign temp = {{11{hot >> 1}}, hot};
  always_ff @(posedge mclk) begin
    {alm, tmo, trp} <= want;
  end
endmodule

// File: rtdc_combiner_tb.sv
// Self-checking bench for the combiner: random sensor flags, voting setup, register bus and interrupt.
// Assumes rtdc_stage_model drives the sensor side.
`timescale 1ns/1ns
module rtdc_combiner_tb;
  logic mclk, rstB, avs_read, avs_write, avs_waitrequest, e1, e2;
  logic combinedAlarm, combinedTimeoutAlarm, combinedTrip, collectiveTimeout, voteTrip1, voteTrip2, tripCmd, irq;
  logic [191:0] sensorTemp;
  logic [11:0] sensorAlarm, sensorTimeout, sensorTrip, chan, s1, s2, tr, al, to;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] groupAlarm, groupTimeout, groupTrip;
  logic [1:0] ctrl;
  logic [15:0] hot;
  logic [9:0] vc;
  logic [63:0] r;
  logic [35:0] want;
  int err_count, tests_run, cyc, seed = 73;
  rtdc_stage_model rtdc_stage_model_inst (.mclk, .want, .hot, .temp(sensorTemp), .alm(sensorAlarm),
    .tmo(sensorTimeout), .trp(sensorTrip));
  rtdc_combiner #(.TICK_CYCLES(4)) rtdc_combiner_inst (.mclk, .rst_b(rstB), .sensorTemp, .sensorAlarm,
    .sensorTimeout, .sensorTrip, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
    .avs_readdata, .avs_waitrequest, .groupAlarm, .groupTimeout, .groupTrip, .combinedAlarm,
    .combinedTimeoutAlarm, .combinedTrip, .collectiveTimeout, .voteTrip1, .voteTrip2, .tripCmd, .irq);
  task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic [3:0] grp(input logic [11:0] f);
    grp = {|f[11:10], |f[9:8], |f[7:6], |f[5:0]};
  endfunction
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (++cyc > 20000) begin
    err_count++;
    stop_test();
  end
  initial begin
    {rstB, avs_read, avs_write, avs_address, avs_writedata, want, hot} = '0;
    repeat (5) @(posedge mclk);
    chk("rst", {voteTrip1, voteTrip2, tripCmd, combinedTrip, irq}, 12'h0);
    rstB <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      ctrl = $random(seed);
      chan = $random(seed);
      s1 = $random(seed);
      s2 = $random(seed);
      vc = $random(seed);
      r = {$random(seed), $random(seed)};
      // Full vote group passes at 11 of 12, one short of 12 does not
      if (i == 0) {ctrl, chan, s1, s2, vc, r} = {2'h3, 12'hFFF, 12'hFFF, 12'h7FF, 10'h3CB, 64'hF_FFFF_FFFF};
      bus(1, 8'h00, {30'h0, ctrl});
      bus(1, 8'h04, {20'h0, chan});
      bus(1, 8'h08, {20'h0, s1});
      bus(1, 8'h0C, {20'h0, s2});
      bus(1, 8'h10, {22'h0, vc});
      want <= r[35:0];
      repeat (6) @(posedge mclk);
      tr = r[11:0] & chan & {12{ctrl[0]}};
      to = r[23:12] & chan & {12{ctrl[0]}};
      al = r[35:24] & chan & {12{ctrl[0]}};
      e1 = vc[8] && vc[3:0] != 0 && $countones(s1 & tr) >= vc[3:0];
      e2 = vc[9] && vc[7:4] != 0 && $countones(s2 & tr) >= vc[7:4];
      chk("gTrp", {8'h0, groupTrip}, {8'h0, grp(tr)});
      chk("gAlm", {8'h0, groupAlarm}, {8'h0, grp(al)});
      chk("gTmo", {8'h0, groupTimeout}, {8'h0, grp(to)});
      chk("cAlm", {11'h0, combinedAlarm}, {11'h0, |al});
      chk("cTmo", {11'h0, combinedTimeoutAlarm}, {11'h0, |to});
      chk("cTrp", {11'h0, combinedTrip}, {11'h0, |tr});
      chk("coll", {11'h0, collectiveTimeout}, {11'h0, |to});
      chk("vote", {10'h0, voteTrip1, voteTrip2}, {10'h0, e1, e2});
      chk("cmd", {11'h0, tripCmd}, {11'h0, ctrl[1] ? e1 | e2 : |tr});
    end
    $display("random voting done");
    want <= '0;
    bus(1, 8'h04, 32'h1);
    bus(1, 8'h00, 32'h1);
    bus(1, 8'h34, 32'h0);
    bus(0, 8'h30, 32'h0);
    bus(0, 8'h30, 32'h0);
    chk("stat", q[11:0], 12'h0);
    bus(0, 8'hFC, 32'h0);
    chk("unmap", q[11:0], 12'h0);
    want <= 36'h1;
    repeat (6) @(posedge mclk);
    chk("masked", {11'h0, irq}, 12'h0);
    bus(1, 8'h34, 32'h4);
    repeat (2) @(posedge mclk);
    chk("irq", {11'h0, irq}, 12'h1);
    bus(0, 8'h30, 32'h0);
    chk("trip bit", {11'h0, q[2]}, 12'h1);
    repeat (2) @(posedge mclk);
    chk("irq clr", {11'h0, irq}, 12'h0);
    $display("interrupt done");
    want <= '0;
    bus(1, 8'h04, 32'h3);
    bus(1, 8'h20, 32'h0200_0100);
    bus(1, 8'h14, 32'h2);
    hot <= 16'h200;
    repeat (6) @(posedge mclk);
    chk("thrTrip", {8'h0, groupTrip}, 12'h1);
    chk("early", {8'h0, groupAlarm}, 12'h0);
    repeat (20) @(posedge mclk);
    chk("dlyAlm", {8'h0, groupAlarm}, 12'h1);
    // Just above the dropout level of the trip threshold
    hot <= 16'h1FB;
    repeat (6) @(posedge mclk);
    chk("hold", {8'h0, groupTrip}, 12'h1);
    hot <= 16'h1F9;
    repeat (6) @(posedge mclk);
    chk("drop", {4'h0, groupAlarm, groupTrip}, 12'h010);
    $display("threshold done");
    stop_test();
  end
endmodule
